// ==== rtl/dual_comparator_control.sv ====
// register block and top of the dual comparator control
// assumes an AXI4-Lite master on clk_sys and analog front ends giving digital levels
`timescale 1ns/1ps
`include "cmp_ctrl_defs.svh"
// Notes on behaviour
// - comparator one runs only when enable set
// - two-bit channel field picks minus input
// - comparator one reference bit picks internal
// - comparator two reference bit picks internal
// - result high when plus exceeds, polarity inverts
// - result sampled per instruction cycle, pin unlatched
// - pin one driven: pin enable, enable, direction
// - pin two driven: pin enable, enable, direction
// - change events independent of pin enable
// - speed bit one normal, zero low power
// - comparator two control mirrors comparator one
// - shared register mirrors both results
// - shared read leaves mismatch state alone
// - gate source bit picks pin or comparator
// - sync bit latches comparator two on fall
// - shared bits five to two read zero
// - event flag set on change edge
// - latch clocked by prescaled timer clock
// - reset restores registers, both comparators off
module dual_comparator_control (
   input wire logic clk_sys, // 25 MHz system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic [2:0] s_axi_awprot, // write protection, unused
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic [2:0] s_axi_arprot, // read protection, unused
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic cmp1_raw, // comparator one analog result level
   input wire logic cmp2_raw, // comparator two analog result level
   input wire logic [7:0] port_a_direction, // port direction bits
   output logic cmp1_enable, // comparator one power
   output logic [1:0] cmp1_channel_select, // comparator one minus input pick
   output logic cmp1_ref_select, // comparator one plus from internal reference
   output logic cmp1_speed, // comparator one normal speed
   output logic cmp2_enable, // comparator two power
   output logic [1:0] cmp2_channel_select, // comparator two minus input pick
   output logic cmp2_ref_select, // comparator two plus from internal reference
   output logic cmp2_speed, // comparator two normal speed
   output logic cmp1_pin_out, // comparator one pin level
   output logic cmp1_pin_oe, // comparator one pin drive enable
   output logic cmp2_pin_out, // comparator two pin level
   output logic cmp2_pin_oe, // comparator two pin drive enable
   input wire logic timer_clk_in, // prescaled timer clock
   input wire logic gate_pin, // external timer gate pin
   output logic timer_gate // timer gate source
);
   cmp_chan_if ch1 ();
   cmp_chan_if ch2 ();

   cmp_ctrl_pkg::ctrl_t ctrl1_reg, ctrl2_reg;
   logic [1:0] shared_reg;
   logic [1:0] events_reg, events_next;
   logic [`CYCLE_CNT_W-1:0] cyc_reg;
   logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
   logic [`ADDR_W-1:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;

   // a register index is decoded for both reads and writes
   function automatic logic [3:0] reg_sel(input logic [`ADDR_W-1:0] a);
      reg_sel = {a == `ADDR_EVENTS, a == `ADDR_SHARED,
                 a == `ADDR_CMP2_CTRL, a == `ADDR_CMP1_CTRL};
   endfunction

   function automatic logic [7:0] ctrl_view(input cmp_ctrl_pkg::ctrl_t c,
                                             input logic res);
      ctrl_view = {c.enable, res, c[5:0]};
   endfunction

   // write channel: address and data taken in either order
   logic aw_take, w_take, have_aw, have_w, wr_fire;
   logic [`ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_lane;
   logic [3:0] wr_sel;
   logic wr_c1, wr_c2, wr_sh, wr_ev;
   assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign have_aw = aw_full_reg | aw_take;
   assign have_w = w_full_reg | w_take;
   assign wr_fire = have_aw & have_w & ~bvalid_reg;
   assign wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
   assign wr_data = w_full_reg ? w_data_reg : s_axi_wdata[7:0];
   assign wr_lane = w_full_reg ? w_strb_reg : s_axi_wstrb[0];
   assign wr_sel = reg_sel(wr_addr);
   assign wr_c1 = wr_fire & wr_lane & wr_sel[0];
   assign wr_c2 = wr_fire & wr_lane & wr_sel[1];
   assign wr_sh = wr_fire & wr_lane & wr_sel[2];
   assign wr_ev = wr_fire & wr_lane & wr_sel[3];
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // read channel: one outstanding read, data one edge after the address
   logic rd_fire;
   logic [3:0] rd_sel;
   logic [7:0] rd_byte;
   assign s_axi_arready = ~rvalid_reg;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign rd_sel = reg_sel(s_axi_araddr);
   assign rd_byte = rd_sel[0] ? ctrl_view(ctrl1_reg, ch1.result) :
                    rd_sel[1] ? ctrl_view(ctrl2_reg, ch2.result) :
                    rd_sel[2] ? {ch1.result, ch2.result, 4'h0, shared_reg} :
                    rd_sel[3] ? {4'h0, ch2.mismatch, ch1.mismatch, events_reg} :
                    8'h00;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // only a control register read settles the mismatch state
   assign ch1.ack_read = rd_fire & rd_sel[0];
   assign ch2.ack_read = rd_fire & rd_sel[1];

   // instruction cycle strobe for the result sample
   logic sample_stb;
   assign sample_stb = cyc_reg == `CYCLE_CNT_W'(`INSTR_CLKS - 1);
   assign ch1.sample_stb = sample_stb;
   assign ch2.sample_stb = sample_stb;
   assign ch1.ctrl = ctrl1_reg;
   assign ch2.ctrl = ctrl2_reg;

   // set beats a write-one clear in the same cycle
   assign events_next = (events_reg & ~(wr_ev ? wr_data[1:0] : 2'h0))
                        | {ch2.change_event, ch1.change_event};

   // front-end controls come straight from the stored fields
   assign cmp1_enable = ctrl1_reg.enable;
   assign cmp1_channel_select = ctrl1_reg.channel_select;
   assign cmp1_ref_select = ctrl1_reg.ref_select;
   assign cmp1_speed = ctrl1_reg.speed;
   assign cmp2_enable = ctrl2_reg.enable;
   assign cmp2_channel_select = ctrl2_reg.channel_select;
   assign cmp2_ref_select = ctrl2_reg.ref_select;
   assign cmp2_speed = ctrl2_reg.speed;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl1_reg <= `CTRL_RESET;
         ctrl2_reg <= `CTRL_RESET;
         shared_reg <= `SHARED_RESET;
         events_reg <= `EVENTS_RESET;
         cyc_reg <= '0;
      end else begin
         if (wr_c1) ctrl1_reg <= wr_data & `CTRL_WMASK;
         if (wr_c2) ctrl2_reg <= wr_data & `CTRL_WMASK;
         if (wr_sh) shared_reg <= wr_data[1:0];
         events_reg <= events_next;
         cyc_reg <= sample_stb ? '0 : cyc_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else if (wr_fire) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         bvalid_reg <= 1'b1;
         bresp_reg <= (|wr_sel) ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
         if (aw_take) aw_full_reg <= 1'b1;
         if (aw_take) aw_addr_reg <= s_axi_awaddr;
         if (w_take) w_full_reg <= 1'b1;
         if (w_take) w_data_reg <= s_axi_wdata[7:0];
         if (w_take) w_strb_reg <= s_axi_wstrb[0];
         if (s_axi_bready) bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h00_0000, rd_byte};
         rresp_reg <= (|rd_sel) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   cmp_channel u_cmp1 (
      .clk_sys(clk_sys),
      .srst(srst),
      .raw_in(cmp1_raw),
      .dir_bit(port_a_direction[`PORTA_BIT_C1]),
      .pin_out(cmp1_pin_out),
      .pin_oe(cmp1_pin_oe),
      .ch(ch1)
   );

   cmp_channel u_cmp2 (
      .clk_sys(clk_sys),
      .srst(srst),
      .raw_in(cmp2_raw),
      .dir_bit(port_a_direction[`PORTA_BIT_C2]),
      .pin_out(cmp2_pin_out),
      .pin_oe(cmp2_pin_oe),
      .ch(ch2)
   );

   // the latch sees the live level so it catches changes between samples
   cmp_tmr_sync u_tmr (
      .clk_sys(clk_sys),
      .srst(srst),
      .tmr_clk_in(timer_clk_in),
      .gate_pin(gate_pin),
      .c2_level(ch2.live),
      .gate_src(shared_reg[`BIT_GATE_SRC]),
      .sync_en(shared_reg[`BIT_SYNC_EN]),
      .timer_gate(timer_gate)
   );

   enable_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_c1 |=> cmp1_enable == $past(wr_data[7]))
      else $error("enable did not follow write");

   enable_two_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_c2 |=> cmp2_enable == $past(wr_data[7]))
      else $error("enable two did not follow write");

   channel_one_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_c1 |=> cmp1_channel_select == $past(wr_data[1:0]))
      else $error("channel one did not follow write");

   channel_two_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_c2 |=> cmp2_channel_select == $past(wr_data[1:0]))
      else $error("channel two did not follow write");

   ref_one_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_c1 |=> cmp1_ref_select == $past(wr_data[2]))
      else $error("reference one did not follow write");

   ref_two_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_c2 |=> cmp2_ref_select == $past(wr_data[2]))
      else $error("reference two did not follow write");

   speed_one_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_c1 |=> cmp1_speed == $past(wr_data[3]))
      else $error("speed one did not follow write");

   speed_two_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_c2 |=> cmp2_speed == $past(wr_data[3]))
      else $error("speed two did not follow write");

   result_polar_a: assert property (@(posedge clk_sys) disable iff (srst)
      sample_stb |=> ch1.result == $past(ch1.live))
      else $error("result not sampled from live level");

   result_two_a: assert property (@(posedge clk_sys) disable iff (srst)
      sample_stb |=> ch2.result == $past(ch2.live))
      else $error("result two not sampled from live level");

   control_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      rd_fire && rd_sel[0] |=> s_axi_rdata[6] == $past(ch1.result))
      else $error("control read result bit wrong");

   disabled_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
      !cmp1_enable && !$past(cmp1_enable) |-> !ch1.live)
      else $error("disabled comparator shows live result");

   disabled_two_a: assert property (@(posedge clk_sys) disable iff (srst)
      !cmp2_enable |-> !ch2.live)
      else $error("disabled comparator two shows live result");

   pin_one_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
      cmp1_pin_oe |-> cmp1_enable && ctrl1_reg.pin_enable
                      && !port_a_direction[`PORTA_BIT_C1])
      else $error("pin one driven without all enables");

   pin_two_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
      cmp2_pin_oe == (cmp2_enable && ctrl2_reg.pin_enable
                      && !port_a_direction[`PORTA_BIT_C2]))
      else $error("pin two enable wrong");

   mirror_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      rd_fire && rd_sel[2] |=> s_axi_rdata[7:6] == $past({ch1.result, ch2.result}))
      else $error("mirror bits differ from results");

   shared_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
      rd_fire && rd_sel[2] |-> !ch1.ack_read && !ch2.ack_read)
      else $error("shared read touched mismatch");

   reserved_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
      rd_fire && rd_sel[2] |=> s_axi_rdata[5:2] == 4'h0)
      else $error("reserved shared bits not zero");

   event_sticky_a: assert property (@(posedge clk_sys) disable iff (srst)
      ch1.change_event |=> events_reg[0])
      else $error("event flag lost");

   event_two_a: assert property (@(posedge clk_sys) disable iff (srst)
      ch2.change_event |=> events_reg[1])
      else $error("event two flag lost");

   event_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_ev && wr_data[0] && !ch1.change_event |=> !events_reg[0])
      else $error("event flag not cleared");

   gate_pick_a: assert property (@(posedge clk_sys) disable iff (srst)
      shared_reg[`BIT_GATE_SRC] && !shared_reg[`BIT_SYNC_EN] ##1
      !shared_reg[`BIT_GATE_SRC] && !shared_reg[`BIT_SYNC_EN]
      |-> timer_gate == ch2.live)
      else $error("gate not from comparator two");

   gate_live_a: assert property (@(posedge clk_sys) disable iff (srst)
      !shared_reg[`BIT_GATE_SRC] && !shared_reg[`BIT_SYNC_EN] |-> timer_gate == ch2.live)
      else $error("unsynchronised gate not live");

   // checked one edge after a reset edge so the first edge of a run sees no unknowns
   reset_state_a: assert property (@(posedge clk_sys)
      srst |=> !cmp1_enable && !cmp2_enable
               && shared_reg == `SHARED_RESET && !s_axi_bvalid)
      else $error("reset state wrong");

   write_resp_a: assert property (@(posedge clk_sys) disable iff (srst)
      wr_fire |=> s_axi_bvalid)
      else $error("write response missing");
endmodule

// ==== rtl/cmp_ctrl_defs.svh ====
// register map, field positions, reset values and timing counts
// assumes a 32-bit AXI4-Lite slave with byte addresses, 25 MHz system clock
`ifndef CMP_CTRL_DEFS_SVH
`define CMP_CTRL_DEFS_SVH
`define ADDR_W 8
`define ADDR_CMP1_CTRL 8'h00
`define ADDR_CMP2_CTRL 8'h04
`define ADDR_SHARED 8'h08
`define ADDR_EVENTS 8'h0c
`define CTRL_RESET 8'h00
`define SHARED_RESET 2'h2
`define EVENTS_RESET 2'h0
`define CTRL_WMASK 8'hbf
`define BIT_GATE_SRC 1
`define BIT_SYNC_EN 0
`define PORTA_BIT_C1 2
`define PORTA_BIT_C2 4
`define INSTR_CLKS 4
`define CYCLE_CNT_W 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== rtl/cmp_ctrl_pkg.sv ====
// types shared by the comparator control block
// assumes cmp_ctrl_defs.svh for all numeric constants
package cmp_ctrl_pkg;
   typedef struct packed {
      logic enable;
      logic result;
      logic pin_enable;
      logic invert;
      logic speed;
      logic ref_select;
      logic [1:0] channel_select;
   } ctrl_t;
endpackage

// ==== rtl/cmp_chan_if.sv ====
// connection between the register block and one comparator channel
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface cmp_chan_if;
   cmp_ctrl_pkg::ctrl_t ctrl;
   logic sample_stb;
   logic ack_read;
   logic result;
   logic live;
   logic mismatch;
   logic change_event;
   modport regs (output ctrl, sample_stb, ack_read,
                 input result, live, mismatch, change_event);
   modport chan (input ctrl, sample_stb, ack_read,
                 output result, live, mismatch, change_event);
endinterface

// ==== rtl/cmp_channel.sv ====
// one comparator channel: input sync, sampled result, pin path, change events
// assumes raw_in is an asynchronous level from the analog front end
`timescale 1ns/1ps
module cmp_channel (
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset
   input wire logic raw_in, // analog comparison, high when plus above minus
   input wire logic dir_bit, // port direction bit, 0 = output
   output logic pin_out, // unlatched result towards the pin
   output logic pin_oe, // pin drive enable
   cmp_chan_if.chan ch // register side
);
   logic s1_reg, s2_reg, s3_reg, stable_reg;
   logic result_reg, seen_reg, mism_d_reg;
   assign ch.live = ch.ctrl.enable & (stable_reg ^ ch.ctrl.invert);
   assign ch.result = result_reg;
   assign ch.mismatch = result_reg ^ seen_reg;
   // edge, not level: a held mismatch fires once
   assign ch.change_event = ch.mismatch & ~mism_d_reg;
   // pin path bypasses the sample flop so its delay stays analog
   assign pin_out = raw_in ^ ch.ctrl.invert;
   assign pin_oe = ch.ctrl.pin_enable & ch.ctrl.enable & ~dir_bit;
   always_ff @(posedge clk_sys) begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (srst) begin
         stable_reg <= 1'b0;
         result_reg <= 1'b0;
         seen_reg <= 1'b0;
         mism_d_reg <= 1'b0;
      end else begin
         if (s2_reg == s3_reg) stable_reg <= s3_reg;
         if (ch.sample_stb) result_reg <= ch.live;
         if (ch.ack_read) seen_reg <= result_reg;
         mism_d_reg <= ch.mismatch;
      end
   end
   sample_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
      !ch.sample_stb |=> $stable(result_reg)) else $error("result moved off sample");
   event_edge_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(ch.mismatch) |-> ch.change_event) else $error("change event missed");
endmodule

// ==== rtl/cmp_tmr_sync.sv ====
// timer gate source selection and comparator two latch on timer clock fall
// assumes tmr_clk_in is the prescaled timer clock, slow against clk_sys
`timescale 1ns/1ps
module cmp_tmr_sync (
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset
   input wire logic tmr_clk_in, // prescaled timer clock pin
   input wire logic gate_pin, // external gate pin
   input wire logic c2_level, // comparator two result
   input wire logic gate_src, // 1 = pin, 0 = comparator two
   input wire logic sync_en, // latch comparator two on timer fall
   output logic timer_gate // gate towards the timer
);
   logic t1_reg, t2_reg, t3_reg, tclk_reg, g1_reg, g2_reg, g3_reg, gate_reg, c2_lat_reg;
   logic t_fall, c2_out;
   assign t_fall = tclk_reg & (t2_reg == t3_reg) & ~t3_reg;
   assign c2_out = sync_en ? c2_lat_reg : c2_level;
   assign timer_gate = gate_src ? gate_reg : c2_out;
   always_ff @(posedge clk_sys) begin
      t1_reg <= tmr_clk_in;
      t2_reg <= t1_reg;
      t3_reg <= t2_reg;
      g1_reg <= gate_pin;
      g2_reg <= g1_reg;
      g3_reg <= g2_reg;
      if (srst) begin
         tclk_reg <= 1'b0;
         gate_reg <= 1'b0;
         c2_lat_reg <= 1'b0;
      end else begin
         if (t2_reg == t3_reg) tclk_reg <= t3_reg;
         if (g2_reg == g3_reg) gate_reg <= g3_reg;
         if (t_fall) c2_lat_reg <= c2_level;
      end
   end
   latch_fall_a: assert property (@(posedge clk_sys) disable iff (srst)
      !t_fall |=> $stable(c2_lat_reg)) else $error("latch moved off timer fall");
endmodule

// ==== verification/cmp_front_model.sv ====
// behavioural analog front ends and prescaled timer clock source
// assumes levels change just after a rising clk_sys edge
`timescale 1ns/1ps
module cmp_front_model (
   input wire logic clk_sys, // system clock
   input wire logic [7:0] plus1, // comparator one plus level
   input wire logic [7:0] minus1, // comparator one minus level
   input wire logic [7:0] plus2, // comparator two plus level
   input wire logic [7:0] minus2, // comparator two minus level
   input wire logic tmr_run, // timer clock runs while high
   output logic raw1, // comparator one comparison
   output logic raw2, // comparator two comparison
   output logic tmr_clk // prescaled timer clock
);
   int div = 0;
   assign raw1 = plus1 > minus1;
   assign raw2 = plus2 > minus2;
   // a stopped clock holds its level so no stray fall reaches the latch
   initial tmr_clk = 1'b0;
   always @(posedge clk_sys) begin
      div <= (div == 5) ? 0 : div + 1;
      if (tmr_run && div == 5) tmr_clk <= ~tmr_clk;
   end
endmodule

// ==== verification/dual_comparator_control_test.sv ====
// self-checking bench for the dual comparator control block
// assumes the front-end model and all rtl files are compiled first
`timescale 1ns/1ps
`include "cmp_ctrl_defs.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module dual_comparator_control_test;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, pdir = 8'hff, v = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [7:0] pl1 = 8'h00, mi1 = 8'h10, pl2 = 8'h00, mi2 = 8'h10;
   logic gpin = 1'b0, trun = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, raw1, raw2, tclk, tgate;
   logic [1:0] bresp, rresp, ch1, ch2, resp;
   logic [31:0] rdata, rd;
   logic en1, rf1, sp1, en2, rf2, sp2, po1, oe1, po2, oe2;
   logic [7:0] ctl_m [2];
   int err_total = 0, n_tests = 0, cyc = 0, c = 0;
   always #20 clk_sys = ~clk_sys;
   cmp_front_model cmp_front_model_inst (.clk_sys(clk_sys), .plus1(pl1), .minus1(mi1),
      .plus2(pl2), .minus2(mi2), .tmr_run(trun), .raw1(raw1), .raw2(raw2), .tmr_clk(tclk));
   dual_comparator_control dual_comparator_control_inst (.clk_sys(clk_sys), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cmp1_raw(raw1), .cmp2_raw(raw2), .port_a_direction(pdir),
      .cmp1_enable(en1), .cmp1_channel_select(ch1), .cmp1_ref_select(rf1),
      .cmp1_speed(sp1), .cmp2_enable(en2), .cmp2_channel_select(ch2),
      .cmp2_ref_select(rf2), .cmp2_speed(sp2), .cmp1_pin_out(po1), .cmp1_pin_oe(oe1),
      .cmp2_pin_out(po2), .cmp2_pin_oe(oe2), .timer_clk_in(tclk), .gate_pin(gpin),
      .timer_gate(tgate));
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // readies are sampled mid-cycle: inputs only move just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      logic [2:0] st;
      st = 3'b000;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (st != 3'b111) begin
         @(negedge clk_sys);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         if (tb) resp = bresp;
         @(posedge clk_sys);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         st = st | {ta, tw, tb};
      end
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      logic ta, tr;
      logic [1:0] st;
      st = 2'b00;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (st != 2'b11) begin
         @(negedge clk_sys);
         ta = arvalid && arready;
         tr = rvalid && rready;
         if (tr) rd = rdata;
         if (tr) resp = rresp;
         @(posedge clk_sys);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
         st = st | {ta, tr};
      end
      `CHK("rdata", {24'h0, e}, rd)
      `CHK("rresp", er, resp)
   endtask
   function automatic logic rawx(int k);
      return k ? (pl2 > mi2) : (pl1 > mi1);
   endfunction
   function automatic logic res(int k);
      return ctl_m[k][7] & (rawx(k) ^ ctl_m[k][4]);
   endfunction
   function automatic logic [7:0] ectl(int k);
      return (ctl_m[k] & 8'hbf) | {1'b0, res(k), 6'h00};
   endfunction
   initial begin
      void'($urandom(32'h2793));
      ctl_m[0] = 8'h00;
      ctl_m[1] = 8'h00;
      tick(20);
      srst <= 1'b0;
      chk_rd(8'h00, 8'h00, `RESP_OKAY);
      `CHK("en1", 1'b0, en1)
      `CHK("oe2", 1'b0, oe2)
      chk_rd(8'h04, 8'h00, `RESP_OKAY);
      chk_rd(8'h08, 8'h02, `RESP_OKAY);
      chk_rd(8'h0c, 8'h00, `RESP_OKAY);
      chk_rd(8'h10, 8'h00, `RESP_SLVERR);
      wr(8'h10, 32'hff);
      `CHK("bresp", `RESP_SLVERR, resp)
      // change events with the pin path left off
      wr(8'h00, 32'h80);
      ctl_m[0] = 8'h80;
      tick(16);
      chk_rd(8'h00, 8'h80, `RESP_OKAY);
      wr(8'h0c, 32'h03);
      chk_rd(8'h0c, 8'h00, `RESP_OKAY);
      @(posedge clk_sys);
      pl1 <= 8'h20;
      tick(16);
      chk_rd(8'h08, 8'h82, `RESP_OKAY);
      chk_rd(8'h0c, 8'h05, `RESP_OKAY);
      chk_rd(8'h00, 8'hc0, `RESP_OKAY);
      chk_rd(8'h0c, 8'h01, `RESP_OKAY);
      wr(8'h0c, 32'h01);
      chk_rd(8'h0c, 8'h00, `RESP_OKAY);
      wr(8'h08, 32'hff);
      chk_rd(8'h08, 8'h83, `RESP_OKAY);
      // random control words, every channel code on both comparators
      for (int i = 0; i < 16; i++) begin
         c = i % 2;
         v = 8'($urandom);
         v[1:0] = 2'(i >> 1);
         @(posedge clk_sys);
         pdir <= 8'($urandom);
         pl1 <= 8'($urandom);
         pl2 <= 8'($urandom);
         wr(8'(4 * c), {24'h0, v});
         ctl_m[c] = v;
         tick(16);
         `CHK("enable", v[7], c ? en2 : en1)
         `CHK("channel", v[1:0], c ? ch2 : ch1)
         `CHK("ref", v[2], c ? rf2 : rf1)
         `CHK("speed", v[3], c ? sp2 : sp1)
         `CHK("pin_oe", v[5] & v[7] & ~pdir[c ? 4 : 2], c ? oe2 : oe1)
         `CHK("pin_out", rawx(c) ^ v[4], c ? po2 : po1)
         chk_rd(8'(4 * c), ectl(c), `RESP_OKAY);
         chk_rd(8'h08, {res(0), res(1), 6'h03}, `RESP_OKAY);
      end
      // pin follows the raw level at once
      @(posedge clk_sys);
      pl1 <= mi1;
      mi1 <= pl1;
      @(negedge clk_sys);
      `CHK("pin_now", rawx(0) ^ ctl_m[0][4], po1)
      // timer gate source and latch on timer clock fall
      wr(8'h04, 32'h80);
      wr(8'h08, 32'h02);
      @(posedge clk_sys);
      gpin <= 1'b1;
      tick(8);
      `CHK("gate_pin1", 1'b1, tgate)
      gpin <= 1'b0;
      tick(8);
      `CHK("gate_pin0", 1'b0, tgate)
      pl2 <= 8'h40;
      mi2 <= 8'h10;
      wr(8'h08, 32'h00);
      tick(8);
      `CHK("gate_live", 1'b1, tgate)
      wr(8'h08, 32'h01);
      trun <= 1'b1;
      tick(40);
      `CHK("gate_sync1", 1'b1, tgate)
      trun <= 1'b0;
      tick(20);
      pl2 <= 8'h00;
      tick(20);
      `CHK("gate_held", 1'b1, tgate)
      trun <= 1'b1;
      tick(40);
      `CHK("gate_sync0", 1'b0, tgate)
      // reset in mid-run
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      chk_rd(8'h04, 8'h00, `RESP_OKAY);
      chk_rd(8'h08, 8'h02, `RESP_OKAY);
      `CHK("en2", 1'b0, en2)
      stop_test();
   end
endmodule
